// ### svd_pkg.sv
package svd_pkg;

    // ------------------------------------------------------------
    // Frame and code sizes
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 14;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
    localparam int PAD_BITS = FRAME_BITS - CODE_BITS;

    // ------------------------------------------------------------
    // Pin synchroniser lanes
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 7;
    localparam int PIN_SEL = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_ORDER = 4;
    localparam int PIN_ALIGN = 5;
    localparam int PIN_LOAD = 6;
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 7'h7F;

    // ------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // ------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] OFS_INPUT = 8'h08;
    localparam logic [ADR_W-1:0] OFS_DAC = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_FRAMES = 8'h10;

    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [CODE_BITS-1:0] LATCH_RESET = 14'h0000;
    localparam int FRAMES_W = 16;

    // STATUS field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_CNT_LSB = 4;
    localparam int ST_ORDER_BIT = 8;
    localparam int ST_ALIGN_BIT = 9;
    localparam int ST_LOAD_BIT = 10;
    localparam int ST_SEL_BIT = 11;

    typedef enum logic [2:0] {
        SVD_IDLE = 3'b001,
        SVD_SHIFT = 3'b010,
        SVD_DONE = 3'b100
    } svd_state_t;

endpackage

// ### svd_pins_if.sv
`timescale 1ns/1ps
`default_nettype none
interface svd_pins_if;
    import svd_pkg::*;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] fall;
    modport src(output level, output fall);
    modport dst(input level, input fall);
endinterface
`default_nettype wire

// ### svd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module svd_pin_sync
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw pins
    input wire logic [PIN_COUNT-1:0] raw,
    // Synchronised levels and falling edges
    svd_pins_if.src pins
);
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_lane
            logic meta;
            logic stable;
            logic prev;
            // First stage feeds only the second
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= PIN_RESET[i];
                    stable <= PIN_RESET[i];
                    prev <= PIN_RESET[i];
                end else begin
                    meta <= raw[i];
                    stable <= meta;
                    prev <= stable;
                end
            end
            assign pins.level[i] = stable;
            assign pins.fall[i] = prev & ~stable;
        end
    endgenerate
endmodule
`default_nettype wire

// ### svd_serial_dac.sv
// How it works
// - Each word arrives as exactly sixteen serial bits.
// - Data is sampled on each falling shift-clock edge.
// - Frame sync low opens a frame of the next sixteen falling edges.
// - Only fourteen of sixteen bits reach the input latch.
// - Order 0, align 0: bits one, two dropped; bit three LSB.
// - Order 0, align 1: bit one LSB, bit fourteen MSB, last two dropped.
// - Order 1, align 0: bits one, two dropped; bit three MSB.
// - Order 1, align 1: bit one MSB, bit fourteen LSB, last two dropped.
// - Falling load strobe copies input latch into DAC latch.
// - Load strobe held low: transfer on sixteenth falling shift edge.
// - Load strobe falling mid-frame does not update on that edge.
// - Strobe falling mid-frame and still low at end: update at sixteenth edge.
// - Strobe falling mid-frame, high again before end: no update.
// - DAC latch holds a two's complement code, -8192 to +8191.
// - Strobe low at the sixteenth edge: input latch write and DAC transfer happen together.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module svd_serial_dac
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins from the host
    input wire logic serial_select_n,
    input wire logic frame_sync_n,
    input wire logic top_bit_or_serial_in,
    input wire logic bit12_or_shift_clock,
    input wire logic bit11_or_order_strap,
    input wire logic bit10_or_align_strap,
    input wire logic output_load_strobe_n,
    // Converter side
    output logic signed [CODE_BITS-1:0] dac_code,
    output logic dac_update
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    svd_pins_if pins ();
    logic [PIN_COUNT-1:0] raw;

    always_comb begin
        raw = '0;
        raw[PIN_SEL] = serial_select_n;
        raw[PIN_SYNC] = frame_sync_n;
        raw[PIN_DATA] = top_bit_or_serial_in;
        raw[PIN_SCLK] = bit12_or_shift_clock;
        raw[PIN_ORDER] = bit11_or_order_strap;
        raw[PIN_ALIGN] = bit10_or_align_strap;
        raw[PIN_LOAD] = output_load_strobe_n;
    end

    svd_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw(raw),
        .pins(pins)
    );

    logic sclk_fall;
    logic load_fall;
    logic sync_low;
    logic load_low;
    logic data_bit;
    logic serial_on;
    logic enable;

    assign sclk_fall = pins.fall[PIN_SCLK];
    assign load_fall = pins.fall[PIN_LOAD];
    assign sync_low = ~pins.level[PIN_SYNC];
    assign load_low = ~pins.level[PIN_LOAD];
    assign data_bit = pins.level[PIN_DATA];
    assign serial_on = enable & ~pins.level[PIN_SEL];

    // ------------------------------------------------------------
    // Bit placement
    // ------------------------------------------------------------
    // First frame bit ends up in sr[FRAME_BITS-1]
    function automatic logic [CODE_BITS-1:0] place_bits(
        input logic [FRAME_BITS-1:0] sr,
        input logic order,
        input logic align
    );
        logic [CODE_BITS-1:0] win;
        logic [CODE_BITS-1:0] rev;
        win = align ? sr[FRAME_BITS-1:PAD_BITS] : sr[CODE_BITS-1:0];
        rev = '0;
        for (int i = 0; i < CODE_BITS; i++) begin
            rev[i] = win[CODE_BITS-1-i];
        end
        return order ? win : rev;
    endfunction

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    svd_state_t state;
    logic [CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic frame_end;

    assign next_shreg = {shreg[FRAME_BITS-2:0], data_bit};
    assign frame_end = (state == SVD_SHIFT) && sclk_fall && (bit_cnt == LAST_BIT);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SVD_IDLE;
        end else begin
            case (state)
                SVD_IDLE: begin
                    if (serial_on && sync_low) begin
                        state <= SVD_SHIFT;
                    end
                end
                // Sync released early drops the partial word
                SVD_SHIFT: begin
                    if (!sync_low || !serial_on) begin
                        state <= SVD_IDLE;
                    end else if (frame_end) begin
                        state <= SVD_DONE;
                    end
                end
                SVD_DONE: begin
                    if (!sync_low) begin
                        state <= SVD_IDLE;
                    end
                end
                default: begin
                    state <= SVD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
            shreg <= '0;
        end else if (state != SVD_SHIFT) begin
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            shreg <= next_shreg;
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Input and DAC latches
    // ------------------------------------------------------------
    logic [CODE_BITS-1:0] input_latch;
    logic [CODE_BITS-1:0] next_code;
    logic order_seen;
    logic align_seen;

    assign order_seen = pins.level[PIN_ORDER];
    assign align_seen = pins.level[PIN_ALIGN];
    assign next_code = place_bits(next_shreg, order_seen, align_seen);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_latch <= LATCH_RESET;
        end else if (frame_end) begin
            input_latch <= next_code;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code <= LATCH_RESET;
            dac_update <= 1'b0;
        end else begin
            dac_update <= 1'b0;
            if (frame_end && load_low) begin
                dac_code <= next_code;
                dac_update <= 1'b1;
            end else if (load_fall && state != SVD_SHIFT) begin
                dac_code <= input_latch;
                dac_update <= 1'b1;
            end
            // strobe high at frame end: nothing
        end
    end

    // ------------------------------------------------------------
    // Frame counter
    // ------------------------------------------------------------
    logic [FRAMES_W-1:0] frames;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frames <= '0;
        end else if (frame_end) begin
            frames <= frames + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic req;
    logic [31:0] rdata;

    assign req = wb_cyc_i & wb_stb_i;

    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i & ~8'h03)
            OFS_CTRL: begin
                rdata[CTRL_EN_BIT] = enable;
            end
            OFS_STATUS: begin
                rdata[ST_STATE_LSB +: 3] = state;
                rdata[ST_CNT_LSB +: CNT_W] = bit_cnt;
                rdata[ST_ORDER_BIT] = order_seen;
                rdata[ST_ALIGN_BIT] = align_seen;
                rdata[ST_LOAD_BIT] = load_low;
                rdata[ST_SEL_BIT] = ~pins.level[PIN_SEL];
            end
            OFS_INPUT: begin
                rdata[CODE_BITS-1:0] = input_latch;
            end
            OFS_DAC: begin
                rdata = 32'(dac_code);
            end
            OFS_FRAMES: begin
                rdata[FRAMES_W-1:0] = frames;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // One wait state; data and ack both registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Write lands on the edge where the master sees ack
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= CTRL_EN_RESET;
        end else if (req && wb_ack_o && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i & ~8'h03) == OFS_CTRL) begin
            enable <= wb_dat_i[CTRL_EN_BIT];
        end
    end

endmodule
`default_nettype wire

// ### svd_serial_dac_properties.sv
`timescale 1ns/1ps
`default_nettype none
module svd_serial_dac_properties
    import svd_pkg::*;
(
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Link and converter
    input wire logic bit12_or_shift_clock,
    input wire logic output_load_strobe_n,
    input wire logic signed [CODE_BITS-1:0] dac_code,
    input wire logic dac_update
);
    // Saturating ages; reset to 0 so nothing fires right after release
    logic [3:0] hi_cnt, lo_cnt, fall_cnt;
    logic [1:0] sclk_q;
    function automatic logic [3:0] sat(input logic [3:0] c);
        return c + {3'h0, c != 4'hF};
    endfunction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= 4'h0;
            lo_cnt <= 4'h0;
            fall_cnt <= 4'h0;
            sclk_q <= 2'h3;
        end else begin
            hi_cnt <= output_load_strobe_n ? sat(hi_cnt) : 4'h0;
            lo_cnt <= output_load_strobe_n ? 4'h0 : sat(lo_cnt);
            fall_cnt <= (sclk_q == 2'h2) ? 4'h0 : sat(fall_cnt);
            sclk_q <= {sclk_q[0], bit12_or_shift_clock};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h4
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_code_cause: assert property ($changed(dac_code) |-> dac_update)
        else $error("code changed without update");
    a_update_strobe: assert property (dac_update |-> hi_cnt < 4'h8)
        else $error("update with strobe long high");
    a_held_frame: assert property (dac_update && lo_cnt == 4'hF |-> fall_cnt < 4'h8)
        else $error("held-low update away from shift edge");
    a_dac_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_DAC && $stable(dac_code)
        |-> wb_dat_o == {{18{dac_code[13]}}, dac_code}) else $error("bad code read");
    c_held: cover property (dac_update && lo_cnt == 4'hF);
    c_strobe: cover property (dac_update && lo_cnt < 4'h8);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind svd_serial_dac svd_serial_dac_properties u_props (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .bit12_or_shift_clock, .output_load_strobe_n,
    .dac_code, .dac_update);
`default_nettype wire

// ### svd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module svd_host_model (
    // Link pins
    output logic frame_sync_n,
    output logic serial_in,
    output logic shift_clock
);
    // Clock stands high outside frames
    initial begin
        frame_sync_n = 1'h1;
        serial_in = 1'h0;
        shift_clock = 1'h1;
    end
    task automatic send(input logic [15:0] w, input int nextra);
        // Non-blocking so a start on a clock edge does not race the sampling flops
        frame_sync_n <= 1'h0;
        for (int i = 0; i < 16 + nextra; i++) begin
            serial_in <= (i < 16) ? w[15 - i] : ~serial_in;
            #24 shift_clock <= 1'h0;
            #24 shift_clock <= 1'h1;
        end
        #24 frame_sync_n <= 1'h1;
        serial_in <= ~serial_in;
        #48;
    endtask
endmodule
`default_nettype wire

// ### svd_serial_dac_tb.sv
`timescale 1ns/1ps
`default_nettype none
module svd_serial_dac_tb
    import svd_pkg::*;
;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [ADR_W-1:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o;
    logic serial_select_n = 1'h0;
    logic bit11_or_order_strap = 1'h0;
    logic bit10_or_align_strap = 1'h0;
    logic output_load_strobe_n = 1'h1;
    logic signed [CODE_BITS-1:0] dac_code;
    logic dac_update;
    wire logic frame_sync_n;
    wire logic top_bit_or_serial_in;
    wire logic bit12_or_shift_clock;
    int miscompares = 0;
    int n_compared = 0;
    int n_upd = 0;
    svd_host_model host (.frame_sync_n, .serial_in(top_bit_or_serial_in),
        .shift_clock(bit12_or_shift_clock));
    svd_serial_dac uut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .serial_select_n, .frame_sync_n,
        .top_bit_or_serial_in, .bit12_or_shift_clock, .bit11_or_order_strap,
        .bit10_or_align_strap, .output_load_strobe_n, .dac_code, .dac_update);
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (dac_update === 1'h1) n_upd <= n_upd + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (wb_ack_o !== 1'h1 && t < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_sel_i <= 4'h0;
        check("ack", {31'h0, wb_ack_o}, 32'h1);
    endtask
    // Own view of where the payload sits in the frame
    function automatic logic [31:0] place(input logic [15:0] w, input logic o, input logic a);
        logic [13:0] p;
        logic [13:0] r;
        p = a ? w[15:2] : w[13:0];
        for (int i = 0; i < 14; i++) r[i] = p[13 - i];
        return {18'h0, o ? p : r};
    endfunction
    task automatic strobe(input logic v);
        @(posedge ref_clk);
        output_load_strobe_n <= v;
    endtask
    task automatic wait_upd(input int base);
        int t;
        t = 0;
        while (n_upd == base && t < 40) begin
            @(posedge ref_clk);
            t++;
        end
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic t_regs();
        wb(1'h0, OFS_CTRL, 32'h0);
        check("ctrl", q, 32'h1);
        wb(1'h0, OFS_STATUS, 32'h0);
        check("status", q, 32'h0000_0801);
        wb(1'h1, 8'h40, 32'hFFFFFFFF);
        wb(1'h0, 8'h40, 32'h0);
        check("unmapped", q, 32'h0);
    endtask
    task automatic t_modes();
        logic [15:0] w;
        int base;
        for (int m = 0; m < 4; m++) begin
            w = 16'hC3A5 ^ (16'h1E0F << m);
            @(posedge ref_clk);
            {bit11_or_order_strap, bit10_or_align_strap} <= m[1:0];
            host.send(w, 0);
            wb(1'h0, OFS_INPUT, 32'h0);
            check("input", q, place(w, m[1], m[0]));
            base = n_upd;
            strobe(1'h0);
            wait_upd(base);
            check("dac", {18'h0, dac_code}, place(w, m[1], m[0]));
            check("updates", n_upd - base, 32'h1);
            strobe(1'h1);
        end
    endtask
    // Disabled block must ignore a whole frame
    task automatic t_ctrl();
        int base;
        wb(1'h0, OFS_FRAMES, 32'h0);
        check("frames", q, 32'h4);
        wb(1'h1, OFS_CTRL, 32'h0);
        wb(1'h0, OFS_CTRL, 32'h0);
        check("ctrl off", q, 32'h0);
        base = n_upd;
        host.send(16'hFFFF, 0);
        wb(1'h0, OFS_INPUT, 32'h0);
        check("input kept", q, place(16'hC3A5 ^ (16'h1E0F << 3), 1'h1, 1'h1));
        wb(1'h0, OFS_FRAMES, 32'h0);
        check("frames kept", q, 32'h4);
        check("no update", n_upd - base, 32'h0);
        wb(1'h1, OFS_CTRL, 32'h1);
        wb(1'h0, OFS_CTRL, 32'h0);
        check("ctrl on", q, 32'h1);
    endtask
    task automatic t_held();
        int base;
        strobe(1'h0);
        repeat (12) @(posedge ref_clk);
        base = n_upd;
        host.send(16'h7FFF, 0);
        wait_upd(base);
        check("held", {18'h0, dac_code}, 32'h1FFF);
        base = n_upd;
        host.send(16'h8000, 4);
        wait_upd(base);
        wb(1'h0, OFS_DAC, 32'h0);
        check("negative", q, 32'hFFFFE000);
        wb(1'h0, OFS_INPUT, 32'h0);
        check("extra", q, 32'h2000);
        check("updates", n_upd - base, 32'h1);
        strobe(1'h1);
    endtask
    task automatic t_mid(input logic hold);
        int base;
        logic [31:0] old;
        base = n_upd;
        old = {18'h0, dac_code};
        fork
            host.send(16'h5A5A, 0);
            begin
                repeat (40) @(posedge ref_clk);
                output_load_strobe_n <= 1'h0;
                repeat (12) @(posedge ref_clk);
                check("early", n_upd - base, 32'h0);
                repeat (20) @(posedge ref_clk);
                if (!hold) output_load_strobe_n <= 1'h1;
            end
        join
        repeat (12) @(posedge ref_clk);
        check("end", {18'h0, dac_code}, hold ? place(16'h5A5A, 1'h1, 1'h1) : old);
        check("count", n_upd - base, {31'h0, hold});
        strobe(1'h1);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        t_regs();
        t_modes();
        t_ctrl();
        t_held();
        t_mid(1'h0);
        t_mid(1'h1);
        final_report();
    end
    // Whole run is near 10 us; this cuts a hang
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
